// ==== inc/jfc_pkg.sv ====
// Shared constants and helper functions for the 64b/66b framer link
package jfc_pkg;

  // Block geometry
  localparam int          DATA_W      = 64;
  localparam int          BLK_W       = 66;
  localparam int          MB_BLOCKS   = 32;
  localparam int          IDX_W       = 5;
  localparam int          SHS_W       = 32;
  localparam int          PAR_W       = 26;
  localparam int          CRC_BITS    = 12;
  localparam int          FEC_BITS    = 26;
  localparam logic [4:0]  LAST_IDX    = 5'h1F;

  // Sync header stream content select encodings
  localparam logic [1:0]  MODE_CRC    = 2'h0;
  localparam logic [1:0]  MODE_FEC    = 2'h2;

  // Header codes as blk[1:0]; blk[0] goes out first
  localparam logic [1:0]  SH_ONE      = 2'h2;
  localparam logic [1:0]  SH_ZERO     = 2'h1;

  // Stream word layout
  localparam int          EOEMB_BIT   = 22;
  localparam logic [4:0]  EOMB_PAT    = 5'h10;
  localparam logic [31:0] CRC_ONES    = 32'h80A88888;
  localparam logic [31:0] FEC_ONES    = 32'h80000000;
  localparam logic [4:0]  CRC_CHK_IDX = 5'h0E;
  localparam logic [4:0]  FEC_CHK_IDX = 5'h1A;

  // Parity generators, leading term implied
  localparam logic [25:0] CRC_TAPS    = 26'h000030F;
  localparam logic [25:0] FEC_TAPS    = 26'h0220211;
  localparam logic [25:0] CRC_MASK    = 26'h0000FFF;
  localparam logic [25:0] FEC_MASK    = 26'h3FFFFFF;

  // Self-synchronous scrambler 1 + x^39 + x^58
  localparam int          SCR_W       = 58;
  localparam int          SCR_TAP_A   = 38;
  localparam int          SCR_TAP_B   = 57;
  localparam logic [57:0] SCR_SEED    = 58'h3FFFFFFFFFFFFFF;

  // Returns {new state, data}; rx selects descrambling
  function automatic logic [121:0] scr_step(input logic [63:0] d,
                                            input logic [57:0] st,
                                            input logic        rx);
    logic [57:0] s;
    logic [63:0] o;
    s = st;
    o = '0;
    for (int i = 0; i < DATA_W; i++) begin
      o[i] = d[i] ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
      s    = {s[56:0], (rx ? d[i] : o[i])};
    end
    return {s, o};
  endfunction

  // Divides 64 data bits, first-sent bit first
  function automatic logic [25:0] par_step(input logic [25:0] st,
                                           input logic [63:0] d,
                                           input logic        fec);
    logic [25:0] s;
    logic        fb;
    s  = st;
    fb = 1'b0;
    for (int i = 0; i < DATA_W; i++) begin
      fb = d[i] ^ (fec ? s[25] : s[11]);
      s  = ({s[24:0], 1'b0} ^ (fb ? (fec ? FEC_TAPS : CRC_TAPS) : '0))
           & (fec ? FEC_MASK : CRC_MASK);
    end
    return s;
  endfunction

  // Stream position of the j-th parity bit, most significant first
  function automatic int par_pos(input int j, input logic fec);
    if (fec) begin
      return (j < EOEMB_BIT) ? j : j + 1;
    end
    return j + j / 3;
  endfunction

endpackage

// ==== inc/jfc_link_if.sv ====
// Parallel 66-bit block link between framer and receiver
`timescale 1ns/10ps
interface jfc_link_if (
  input wire logic i_clk
);
  logic [65:0] blk;
  logic        blk_valid;

  modport tx (input i_clk, output blk, output blk_valid);
  modport rx (input i_clk, input blk, input blk_valid);
endinterface

// ==== core/jfc_tx.sv ====
// Transmit framer: 64b/66b blocks, multiblocks, LEMC and header stream
//
// Summary of operation
// (R1) Pack eight octets, scramble, add header
// (R2) Header bits 0-1, octet n follows
// (R3) Thirty-two blocks form one multiblock
// (R4) E multiblocks per extended multiblock
// (R5) SYSREF resets extended multiblock clock phase
// (R6) LEMC ticks once per extended multiblock
// (R7) Periodic SYSREF divides the LEMC rate
// (R8) Header always 01 or 10
// (R9) Receiver finds blocks by header transitions
// (R10) Bad headers make receiver request realignment
// (R11) 01 sends one, 10 sends zero
// (R12) Only CRC-12 or FEC stream content
// (R13) Word ends 00001, unique in CRC mode
// (R14) Bit 22 flags last multiblock
// (R15) Parity of one multiblock sent next
// (R16) Receiver compares own parity with received
// (R17) First-bit error detectable 46 blocks later
// (R18) Select value 0 gives CRC-12
// (R19) CRC parity, fixed ones, zero command bits
// (R20) Divide 2048 data bits by 0x987
// (R21) Clear parity per multiblock, data only
// (R22) Select value 2 gives FEC
// (R23) Block k carries stream bit k
`timescale 1ns/10ps
module jfc_tx #(
  parameter int EMB_MULTIBLOCKS = 1
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Configuration and timing
  input  wire logic [1:0]  i_header_stream_content_select,
  input  wire logic        i_sysref,
  // Transport-layer octets, octet 0 in bits 7:0
  input  wire logic [63:0] i_octets,
  output      logic        o_octets_ready,
  output      logic        o_lemc,
  // Serial-side block link
  jfc_link_if.tx           link
);

  localparam int MB_W = (EMB_MULTIBLOCKS > 1) ? $clog2(EMB_MULTIBLOCKS) : 1;
  localparam logic [MB_W-1:0] MB_LAST = MB_W'(EMB_MULTIBLOCKS - 1);

  logic                   fec;
  logic                   sref_s1_r;
  logic                   sref_s2_r;
  logic                   sref_s3_r;
  logic                   sref_lvl_r;
  logic                   sref_edge;
  logic [4:0]             blk_idx_r;
  logic [MB_W-1:0]        mb_idx_r;
  logic [MB_W-1:0]        mb_idx_nxt;
  logic                   blk_last;
  logic                   mb_last;
  logic [57:0]            scr_r;
  logic [121:0]           scr_res;
  logic [63:0]            scr_data;
  logic [25:0]            par_r;
  logic [25:0]            par_nxt;
  logic [25:0]            hpar_r;
  logic                   eoemb_r;
  logic [31:0]            hdr_word;
  logic [65:0]            blk_r;
  logic                   valid_r;
  logic                   lemc_r;
  logic                   run_r;

  // Anything but the FEC code falls back to CRC-12
  assign fec = (i_header_stream_content_select == jfc_pkg::MODE_FEC); // R18 R22 R12

  // Build one stream word from a finished parity word
  function automatic logic [31:0] build_word(input logic [25:0] p,
                                             input logic        eoemb,
                                             input logic        f);
    logic [31:0] w;
    int          nb;
    w  = f ? jfc_pkg::FEC_ONES : jfc_pkg::CRC_ONES; // R13 R19
    nb = f ? jfc_pkg::FEC_BITS : jfc_pkg::CRC_BITS;
    w[jfc_pkg::EOEMB_BIT] = eoemb; // R14
    for (int j = 0; j < jfc_pkg::PAR_W; j++) begin
      if (j < nb) begin
        w[jfc_pkg::par_pos(j, f)] = p[nb - 1 - j]; // R19
      end
    end
    return w;
  endfunction

  // SYSREF pin synchroniser; a level counts once stages two
  // and three agree, so a one-clock glitch never moves LEMC
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sref_s1_r  <= 1'b0;
      sref_s2_r  <= 1'b0;
      sref_s3_r  <= 1'b0;
      sref_lvl_r <= 1'b0;
    end else begin
      sref_s1_r <= i_sysref;
      sref_s2_r <= sref_s1_r;
      sref_s3_r <= sref_s2_r;
      if (sref_s2_r == sref_s3_r) begin
        sref_lvl_r <= sref_s3_r;
      end
    end
  end

  assign sref_edge = sref_s2_r & sref_s3_r & ~sref_lvl_r;

  assign blk_last   = (blk_idx_r == jfc_pkg::LAST_IDX); // R3
  assign mb_last    = (mb_idx_r == MB_LAST); // R4
  assign mb_idx_nxt = mb_last ? '0 : mb_idx_r + MB_W'(1);

  // Block and multiblock position; one block per clock, so
  // the LEMC period is 32*E clocks of 66 lane bits each
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      blk_idx_r <= '0;
      mb_idx_r  <= '0;
    end else if (sref_edge) begin
      blk_idx_r <= '0; // R5
      mb_idx_r  <= '0; // R5
    end else begin
      blk_idx_r <= blk_idx_r + 5'h01; // R3
      if (blk_last) begin
        mb_idx_r <= mb_idx_nxt; // R4 R6
      end
    end
  end

  // LEMC marks the block that opens an extended multiblock
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      lemc_r <= 1'b0;
    end else begin
      lemc_r <= (blk_idx_r == '0) && (mb_idx_r == '0); // R6
    end
  end

  assign o_lemc = lemc_r;

  // Scrambler runs ahead of the parity and the header
  assign scr_res  = jfc_pkg::scr_step(i_octets, scr_r, 1'b0); // R1
  assign scr_data = scr_res[63:0];

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      scr_r <= jfc_pkg::SCR_SEED;
    end else begin
      scr_r <= scr_res[121:64]; // R1
    end
  end

  // Parity covers scrambled data only, never header bits
  assign par_nxt = jfc_pkg::par_step(par_r, scr_data, fec); // R20 R21

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      par_r <= '0;
    end else if (sref_edge || blk_last) begin
      par_r <= '0; // R21
    end else begin
      par_r <= par_nxt; // R20
    end
  end

  // Word for the next multiblock carries this one's parity.
  // After SYSREF the cut multiblock's parity is dropped; the
  // receiver sees one bad parity compare at most.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      hpar_r  <= '0;
      eoemb_r <= (EMB_MULTIBLOCKS == 1);
    end else if (sref_edge) begin
      hpar_r  <= '0; // R5
      eoemb_r <= (EMB_MULTIBLOCKS == 1); // R5
    end else if (blk_last) begin
      hpar_r  <= par_nxt; // R15
      eoemb_r <= (mb_idx_nxt == MB_LAST); // R14
    end
  end

  // Word follows the live select, so the first multiblock
  // after reset already has the chosen layout
  assign hdr_word = build_word(hpar_r, eoemb_r, fec); // R12 R13 R19

  // Output block: header from stream bit k, then octets 0..7
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      blk_r   <= {64'h0000000000000000, jfc_pkg::SH_ZERO}; // R8
      valid_r <= 1'b0;
    end else begin
      blk_r   <= {scr_data,
                  (hdr_word[blk_idx_r] ? jfc_pkg::SH_ONE
                                     : jfc_pkg::SH_ZERO)}; // R1 R2 R8 R11 R23
      valid_r <= 1'b1;
    end
  end

  // Octets are taken every clock from the first edge after reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      run_r <= 1'b0;
    end else begin
      run_r <= 1'b1;
    end
  end

  assign o_octets_ready = run_r;
  assign link.blk       = blk_r;
  assign link.blk_valid = valid_r;

endmodule

// ==== core/jfc_rx.sv ====
// Receive end: header check, multiblock lock, parity and EoEMB check
`timescale 1ns/10ps
module jfc_rx #(
  parameter int EMB_MULTIBLOCKS = 1,
  parameter int HDR_ERR_LIMIT   = 4
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Configuration and timing
  input  wire logic [1:0]  i_header_stream_content_select,
  input  wire logic        i_sysref,
  // Serial-side block link
  jfc_link_if.rx           link,
  // Descrambled data and status
  output      logic [63:0] o_octets,
  output      logic        o_octets_valid,
  output      logic        o_mb_locked,
  output      logic        o_hdr_err,
  output      logic        o_realign_req,
  output      logic        o_parity_err,
  output      logic        o_eomb_err,
  output      logic        o_eoemb_err
);

  localparam int MB_W = (EMB_MULTIBLOCKS > 1) ? $clog2(EMB_MULTIBLOCKS) : 1;
  localparam logic [MB_W-1:0] MB_LAST = MB_W'(EMB_MULTIBLOCKS - 1);
  localparam logic [7:0] ERR_LIM = 8'(HDR_ERR_LIMIT);

  logic              fec;
  logic              vld;
  logic              sbit;
  logic              hdr_ok;
  logic              sref_s1_r;
  logic              sref_s2_r;
  logic              sref_s3_r;
  logic              sref_lvl_r;
  logic              sref_edge;
  logic [31:0]       sh_r;
  logic [31:0]       cand;
  logic              match;
  logic              locked_r;
  logic [4:0]        idx_r;
  logic [31:0]       word_r;
  logic [31:0]       cur_word;
  logic [25:0]       calc_r;
  logic [25:0]       calc_nxt;
  logic [25:0]       prev_r;
  logic              prev_ok_r;
  logic [MB_W-1:0]   rmb_r;
  logic              emb_seen_r;
  logic [7:0]        herr_r;
  logic [57:0]       dscr_r;
  logic [121:0]      dscr_res;

  assign fec    = (i_header_stream_content_select == jfc_pkg::MODE_FEC);
  assign vld    = link.blk_valid;
  assign hdr_ok = link.blk[0] ^ link.blk[1]; // R10
  assign sbit   = link.blk[1]; // R11

  // Extract parity from a stream word
  function automatic logic [25:0] get_par(input logic [31:0] w,
                                          input logic        f);
    logic [25:0] p;
    int          nb;
    p  = '0;
    nb = f ? jfc_pkg::FEC_BITS : jfc_pkg::CRC_BITS;
    for (int j = 0; j < jfc_pkg::PAR_W; j++) begin
      if (j < nb) begin
        p[nb - 1 - j] = w[jfc_pkg::par_pos(j, f)];
      end
    end
    return p;
  endfunction

  // A level counts once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sref_s1_r  <= 1'b0;
      sref_s2_r  <= 1'b0;
      sref_s3_r  <= 1'b0;
      sref_lvl_r <= 1'b0;
    end else begin
      sref_s1_r <= i_sysref;
      sref_s2_r <= sref_s1_r;
      sref_s3_r <= sref_s2_r;
      if (sref_s2_r == sref_s3_r) begin
        sref_lvl_r <= sref_s3_r;
      end
    end
  end

  assign sref_edge = sref_s2_r & sref_s3_r & ~sref_lvl_r;

  // Pilot search: 00001 at the end, CRC fixed ones in place
  assign cand  = {sbit, sh_r[31:1]};
  assign match = (cand[31:27] == jfc_pkg::EOMB_PAT) &&
                 (fec || ((cand & jfc_pkg::CRC_ONES) == jfc_pkg::CRC_ONES));

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sh_r <= '0;
    end else if (vld) begin
      sh_r <= cand;
    end
  end

  // Lock drops on a bad pilot, on SYSREF and on realign request
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      locked_r   <= 1'b0;
      idx_r      <= '0;
      o_eomb_err <= 1'b0;
    end else begin
      o_eomb_err <= 1'b0;
      if (sref_edge || o_realign_req) begin
        locked_r <= 1'b0; // R10
      end else if (vld) begin
        idx_r <= idx_r + 5'h01;
        if (!locked_r && match && hdr_ok) begin
          locked_r <= 1'b1; // R9
          idx_r    <= '0;
        end else if (locked_r && idx_r == jfc_pkg::LAST_IDX && !match) begin
          locked_r   <= 1'b0;
          o_eomb_err <= 1'b1; // R13
        end
      end
    end
  end

  // Repeated bad headers raise a realign request until SYSREF
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      herr_r        <= '0;
      o_hdr_err     <= 1'b0;
      o_realign_req <= 1'b0;
    end else begin
      o_hdr_err <= vld && !hdr_ok; // R10
      if (vld && !hdr_ok && herr_r != ERR_LIM) begin
        herr_r <= herr_r + 8'h01;
      end else if (sref_edge) begin
        herr_r <= '0;
      end
      // Reaching the limit sets and wins over SYSREF; a held
      // full count must not block the clear afterwards
      if (vld && !hdr_ok && herr_r == ERR_LIM - 8'h01) begin
        o_realign_req <= 1'b1; // R10
      end else if (sref_edge) begin
        o_realign_req <= 1'b0;
      end
    end
  end

  // Own parity per multiblock; compare when last parity bit lands
  assign calc_nxt = jfc_pkg::par_step(calc_r, link.blk[65:2], fec); // R16

  always_comb begin
    cur_word        = word_r;
    cur_word[idx_r] = sbit;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      calc_r       <= '0;
      prev_r       <= '0;
      prev_ok_r    <= 1'b0;
      word_r       <= '0;
      o_parity_err <= 1'b0;
    end else begin
      o_parity_err <= 1'b0;
      if (!locked_r) begin
        calc_r    <= '0;
        prev_ok_r <= 1'b0;
      end else if (vld) begin
        word_r[idx_r] <= sbit;
        if (idx_r == jfc_pkg::LAST_IDX) begin
          calc_r    <= '0;
          prev_r    <= calc_nxt;
          prev_ok_r <= 1'b1;
        end else begin
          calc_r <= calc_nxt;
        end
        if (prev_ok_r && idx_r == (fec ? jfc_pkg::FEC_CHK_IDX
                                       : jfc_pkg::CRC_CHK_IDX)) begin
          o_parity_err <= (get_par(cur_word, fec) != prev_r); // R16 R17
        end
      end
    end
  end

  // EoEMB must appear exactly every E multiblocks
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rmb_r       <= '0;
      emb_seen_r  <= 1'b0;
      o_eoemb_err <= 1'b0;
    end else begin
      o_eoemb_err <= 1'b0;
      if (!locked_r) begin
        emb_seen_r <= 1'b0;
        rmb_r      <= '0;
      end else if (vld && idx_r == jfc_pkg::LAST_IDX && match) begin
        rmb_r <= (cand[jfc_pkg::EOEMB_BIT] || rmb_r == MB_LAST)
                 ? '0 : rmb_r + MB_W'(1);
        if (cand[jfc_pkg::EOEMB_BIT]) begin
          emb_seen_r <= 1'b1;
        end
        o_eoemb_err <= emb_seen_r &&
                       (cand[jfc_pkg::EOEMB_BIT] != (rmb_r == MB_LAST));
      end
    end
  end

  // Descrambler resynchronises itself after 58 bits
  assign dscr_res = jfc_pkg::scr_step(link.blk[65:2], dscr_r, 1'b1);

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      dscr_r         <= jfc_pkg::SCR_SEED;
      o_octets       <= '0;
      o_octets_valid <= 1'b0;
    end else begin
      o_octets_valid <= vld;
      if (vld) begin
        dscr_r   <= dscr_res[121:64];
        o_octets <= dscr_res[63:0];
      end
    end
  end

  assign o_mb_locked = locked_r;

endmodule

// ==== bench/jfc_link_assertions.sv ====
// Link-side assertions for the framer to receiver block stream
`timescale 1ns/10ps
module jfc_link_assertions #(
  parameter int EMB_MULTIBLOCKS = 1
) (
  // Clock, reset and controls
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic [1:0]  i_header_stream_content_select,
  input wire logic        i_sysref,
  // Link signals
  input wire logic [65:0] blk,
  input wire logic        blk_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  logic [31:0] sh_r;
  logic [11:0] acc_r;
  logic [11:0] prv_r;
  logic [11:0] par;
  logic [5:0]  fill_r;
  logic [5:0]  gap_r;
  logic [4:0]  idx_r;
  logic [7:0]  mbs_r;
  logic        seen_r;
  logic        sys_r;
  logic        hit;
  logic        crc;

  function automatic logic [11:0] crc_step(logic [11:0] s, logic [63:0] d);
    for (int i = 0; i < 64; i++)
      s = {s[10:0], 1'b0} ^ ((d[i] ^ s[11]) ? 12'h30F : 12'h000);
    return s;
  endfunction

  // A sysref cuts the multiblock, so word checks stop until reset
  assign crc = (i_header_stream_content_select != 2'h2) && !sys_r;
  assign hit = fill_r[5] && (sh_r[31:27] == 5'h10);
  assign par = {sh_r[0], sh_r[1], sh_r[2], sh_r[4], sh_r[5], sh_r[6],
                sh_r[8], sh_r[9], sh_r[10], sh_r[12], sh_r[13], sh_r[14]};

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sh_r   <= 32'h0;
      acc_r  <= 12'h0;
      prv_r  <= 12'h0;
      fill_r <= 6'h0;
      gap_r  <= 6'h0;
      idx_r  <= 5'h0;
      mbs_r  <= 8'h0;
      seen_r <= 1'b0;
      sys_r  <= 1'b0;
    end else begin
      if (i_sysref)
        sys_r <= 1'b1;
      if (blk_valid) begin
        sh_r   <= {blk[1], sh_r[31:1]};
        fill_r <= fill_r[5] ? fill_r : fill_r + 6'h1;
        gap_r  <= hit ? 6'h1 : gap_r + 6'h1;
        idx_r  <= idx_r + 5'h1;
        acc_r  <= crc_step(hit ? 12'h000 : acc_r, blk[65:2]);
        if (hit) begin
          prv_r  <= acc_r;
          seen_r <= 1'b1;
          mbs_r  <= sh_r[22] ? 8'h0 : mbs_r + 8'h1;
        end
      end
    end
  end

  a_hdr_complement: assert property (
    blk_valid |-> blk[0] != blk[1]) else $error("header bits equal");
  a_valid_steady: assert property (
    $past(i_resetn) |-> blk_valid) else $error("block missing");
  a_pilot_gap: assert property (
    crc && seen_r && hit |-> gap_r == 6'h20) else $error("pilot misplaced");
  a_pilot_period: assert property (
    crc && hit |-> ##32 (hit || sys_r)) else $error("multiblock not 32");
  a_fixed_bits: assert property (
    crc && hit |-> (sh_r & 32'hFFBF8888) == 32'h80A88888)
    else $error("fixed stream bits wrong");
  a_parity_word: assert property (
    crc && seen_r && hit |-> par == prv_r) else $error("parity wrong");
  a_eoemb_flag: assert property (
    crc && hit |-> sh_r[22] == (int'(mbs_r) == EMB_MULTIBLOCKS - 1))
    else $error("end of extended multiblock flag wrong");
  a_fec_pilot: assert property (
    i_header_stream_content_select == 2'h2 && !sys_r && fill_r[5] &&
    idx_r == 5'h0 |-> sh_r[31:27] == 5'h10) else $error("fec pilot wrong");

  c_parity: cover property (crc && seen_r && hit);
  c_fec: cover property (i_header_stream_content_select == 2'h2 && hit);
  c_sysref: cover property (sys_r && blk_valid);
endmodule

// ==== bench/jfc_64b66b_block_framer_crc12_tb_top.sv ====
// Bench joining framer and receiver, plus a faulty link to a second receiver
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module jfc_64b66b_block_framer_crc12_tb_top;
  logic        i_clk    = 1'b0;
  logic        i_resetn = 1'b0;
  logic [1:0]  mode     = 2'h0;
  logic        sysref   = 1'b0;
  logic        sysref_b = 1'b0;
  logic [63:0] octets   = 64'h0;
  logic [57:0] scr;
  logic        rdy, lemc, lock, hdr, perr, eomb, eoemb, hdr_b, realign_b;
  logic [63:0] rx_oct;
  logic        rx_ov, realign;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          errs      = 0;
  int          hcnt      = 0;

  always #25 i_clk = ~i_clk;

  jfc_link_if link_a (.i_clk(i_clk));
  jfc_link_if link_b (.i_clk(i_clk));

  jfc_tx #(.EMB_MULTIBLOCKS(2)) jfc_tx_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_header_stream_content_select(mode),
    .i_sysref(sysref), .i_octets(octets), .o_octets_ready(rdy),
    .o_lemc(lemc), .link(link_a));
  jfc_rx #(.EMB_MULTIBLOCKS(2)) jfc_rx_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_header_stream_content_select(mode),
    .i_sysref(sysref), .link(link_a), .o_octets(rx_oct),
    .o_octets_valid(rx_ov), .o_mb_locked(lock), .o_hdr_err(hdr),
    .o_realign_req(realign),
    .o_parity_err(perr), .o_eomb_err(eomb), .o_eoemb_err(eoemb));
  // Second receiver fed by a deliberately broken link
  jfc_rx #(.EMB_MULTIBLOCKS(2)) jfc_rx_b_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_header_stream_content_select(mode),
    .i_sysref(sysref_b), .link(link_b), .o_octets(), .o_octets_valid(),
    .o_mb_locked(), .o_hdr_err(hdr_b), .o_realign_req(realign_b),
    .o_parity_err(), .o_eomb_err(), .o_eoemb_err());
  jfc_link_assertions #(.EMB_MULTIBLOCKS(2)) jfc_link_assertions_inst (
    .i_clk(i_clk), .i_resetn(i_resetn),
    .i_header_stream_content_select(mode), .i_sysref(sysref),
    .blk(link_a.blk), .blk_valid(link_a.blk_valid));

  // Flags are high one cycle per flagged block, so the falling edge counts each block once
  always @(negedge i_clk) begin
    if (i_resetn && (perr | eomb | eoemb | hdr) === 1'b1)
      errs++;
    if (hdr_b === 1'b1)
      hcnt++;
  end

  function automatic logic [63:0] scramble(logic [63:0] d);
    logic [63:0] o;
    for (int i = 0; i < 64; i++) begin
      o[i] = d[i] ^ scr[38] ^ scr[57];
      scr  = {scr[56:0], o[i]};
    end
    return o;
  endfunction

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(negedge i_clk);
    i_resetn = 1'b0;
    mode = m;
    repeat (10) @(negedge i_clk);
    `CHK(link_a.blk, 66'h1)
    `CHK({link_a.blk_valid, rdy, lemc}, 3'h0)
    i_resetn = 1'b1;
  endtask

  task automatic t_stream(input logic [1:0] m);
    logic [31:0] w;
    logic [63:0] exp_d;
    logic [63:0] prev_o;
    do_reset(m);
    w = (m == 2'h2) ? 32'h80000000 : 32'h80A88888;
    scr = 58'h3FFFFFFFFFFFFFF;
    errs = 0;
    for (int k = 0; k < 200; k++) begin
      octets = {8{k[7:0]}} ^ 64'h0706050403020100;
      exp_d = scramble(octets);
      @(negedge i_clk);
      `CHK(link_a.blk[65:2], exp_d)
      if (k < 32)
        `CHK(link_a.blk[1:0], w[k] ? 2'h2 : 2'h1)
      if (k == 54)
        `CHK(link_a.blk[1:0], 2'h2)
      `CHK(lemc, k % 64 == 0)
      // Receiver hands back block k-1 descrambled
      if (k > 0)
        `CHK({rx_ov, rx_oct}, {1'b1, prev_o})
      prev_o = octets;
    end
    `CHK(lock, 1'b1)
    `CHK(errs, 0)
    `CHK(realign, 1'b0)
  endtask

  task automatic t_sysref();
    int t;
    do_reset(2'h0);
    repeat (20) @(negedge i_clk);
    sysref = 1'b1;
    for (t = 0; t < 10 && lemc !== 1'b1; t++) begin
      @(negedge i_clk);
      if (t == 1)
        sysref = 1'b0;
    end
    sysref = 1'b0;
    `CHK(lemc, 1'b1)
    // A second SYSREF one LEMC period later must not move it
    repeat (64 - t) @(negedge i_clk);
    sysref = 1'b1;
    repeat (2) @(negedge i_clk);
    sysref = 1'b0;
    repeat (t - 3) @(negedge i_clk);
    `CHK(lemc, 1'b0)
    @(negedge i_clk);
    `CHK(lemc, 1'b1)
    repeat (200) @(negedge i_clk);
    `CHK(lock, 1'b1)
  endtask

  // Bad headers alternate 00 and 11, then clean blocks follow
  task automatic send_b(input int nbad);
    for (int k = 0; k < nbad + 3; k++) begin
      link_b.blk = {{32{k[1:0]}}, (k < nbad) ? {2{k[0]}} : 2'h1};
      link_b.blk_valid = 1'b1;
      @(negedge i_clk);
    end
    link_b.blk = ~link_b.blk;
    link_b.blk_valid = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask

  task automatic t_bad_hdr();
    int t;
    do_reset(2'h0);
    hcnt = 0;
    send_b(3);
    `CHK(hcnt, 3)
    `CHK(realign_b, 1'b0)
    send_b(1);
    `CHK(hcnt, 4)
    `CHK(realign_b, 1'b1)
    sysref_b = 1'b1;
    for (t = 0; t < 10 && realign_b !== 1'b0; t++) begin
      @(negedge i_clk);
      if (t == 1)
        sysref_b = 1'b0;
    end
    sysref_b = 1'b0;
    `CHK(realign_b, 1'b0)
  endtask

  initial begin
    link_b.blk = 66'h2AAAAAAAAAAAAAAAA;
    link_b.blk_valid = 1'b0;
    for (int m = 0; m < 4; m++)
      t_stream(m[1:0]);
    t_sysref();
    t_bad_hdr();
    complete_run();
  end

  // Whole run is near 1200 cycles; the limit allows over three times that
  initial begin
    #200us;
    error_cnt++;
    complete_run();
  end
endmodule
